/* File: rtl/rtid_map.svh */
`ifndef RTID_MAP_SVH
`define RTID_MAP_SVH
// register offsets
`define RTID_OFS_RAIL_A_METER 8'h0c
`define RTID_OFS_RAIL_B_METER 8'h0e
`define RTID_OFS_RAIL_C_METER 8'h0f
`define RTID_OFS_POWER_REPORT_SELECT 8'h1a
`define RTID_OFS_METER_KIND_SELECT 8'h1b
`define RTID_OFS_CONVERTER_CONTROL 8'h30
`define RTID_OFS_CONVERTER_RESULT 8'h31
// field positions
`define RTID_BIT_TOTAL_POWER 1
`define RTID_BIT_POWER_KIND 6
`define RTID_CONV_SEL_HI 7
`define RTID_CONV_SEL_LO 3
`define RTID_AVG_HI 1
`define RTID_AVG_LO 0
// reset values
`define RTID_RST_REG 8'h00
// identity codes per strap state
`define RTID_ID_GROUND 4'h9
`define RTID_ID_OPEN 4'h8
`define RTID_ID_HIGH 4'hc
// averaging windows as log2 of the sample count, per setting 0..3
`define RTID_AVG_LOG2_0 4'h0
`define RTID_AVG_LOG2_1 4'h2
`define RTID_AVG_LOG2_2 4'h4
`define RTID_AVG_LOG2_3 4'h6
`endif

/* File: rtl/rtid_pkg.sv */
package rtid_pkg;
    // converter source, high five bits of the control field
    typedef enum logic [4:0] {
        RTID_SRC_OFF = 5'h00,
        RTID_SRC_BULK = 5'h01,
        RTID_SRC_RAIL_A = 5'h02,
        RTID_SRC_RAIL_B = 5'h03,
        RTID_SRC_RAIL_C = 5'h04,
        RTID_SRC_LDO_HIGH = 5'h05,
        RTID_SRC_LDO_LOW = 5'h06
    } rtid_src_t;
    // strap sampling state
    typedef enum logic [2:0] {
        RTID_ST_WAIT = 3'b001,
        RTID_ST_SAMPLE = 3'b010,
        RTID_ST_HELD = 3'b100
    } rtid_strap_st_t;
    typedef logic [7:0] rtid_byte_t;
endpackage

/* File: rtl/rtid_avg_if.sv */
interface rtid_avg_if;
    logic [7:0] sample;
    logic [3:0] log2_len;
    logic [7:0] average;
    logic done;
    modport ctl (output sample, output log2_len, input average, input done);
    modport avg (input sample, input log2_len, output average, output done);
endinterface

/* File: rtl/rtid_averager.sv */
`include "rtid_map.svh"
module rtid_averager (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // sample stream and result
    rtid_avg_if.avg bus
);
    import rtid_pkg::*;
    logic [15:0] acc;
    logic [7:0] cnt;
    logic [7:0] last;
    logic [15:0] sum;
    logic [3:0] len_q;
    logic restart;
    logic [15:0] base_acc;
    logic [7:0] base_cnt;

    // last index of the window, window length is a power of two
    assign last = 8'((16'h1 << bus.log2_len) - 16'h1);
    // a new length drops the partial sum: a shrink would otherwise divide a long sum by a short length
    assign restart = (bus.log2_len != len_q);
    assign base_acc = restart ? 16'h0000 : acc;
    assign base_cnt = restart ? 8'h00 : cnt;
    assign sum = base_acc + {8'h00, bus.sample};

    // window length seen at the previous edge
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            len_q <= `RTID_AVG_LOG2_0;
        end else begin
            len_q <= bus.log2_len;
        end
    end

    // accumulate one sample per cycle; result refreshes once per window
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            acc <= 16'h0000;
            cnt <= 8'h00;
            bus.average <= `RTID_RST_REG;
            bus.done <= 1'b0;
        end else if (base_cnt >= last) begin
            bus.average <= 8'(sum >> bus.log2_len);
            acc <= 16'h0000;
            cnt <= 8'h00;
            bus.done <= 1'b1;
        end else begin
            acc <= sum;
            cnt <= base_cnt + 8'h01;
            bus.done <= 1'b0;
        end
    end
endmodule

/* File: rtl/rtid_telemetry.sv */
`include "rtid_map.svh"
module rtid_telemetry (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // register port
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire rtid_pkg::rtid_byte_t i_reg_wdata,
    output rtid_pkg::rtid_byte_t o_reg_rdata,
    // analog front end: digitised samples
    input wire logic [7:0] i_volt_bulk,
    input wire logic [7:0] i_volt_rail_a,
    input wire logic [7:0] i_volt_rail_b,
    input wire logic [7:0] i_volt_rail_c,
    input wire logic [7:0] i_volt_ldo_high,
    input wire logic [7:0] i_volt_ldo_low,
    input wire logic [7:0] i_cur_rail_a,
    input wire logic [7:0] i_cur_rail_b,
    input wire logic [7:0] i_cur_rail_c,
    input wire logic [7:0] i_pwr_rail_a,
    input wire logic [7:0] i_pwr_rail_b,
    input wire logic [7:0] i_pwr_rail_c,
    input wire logic [7:0] i_pwr_total,
    // strap and supply detection
    input wire logic i_bulk_supply_good,
    input wire logic [1:0] i_identity_strap,
    // identity for the bus front end, and converter enable
    output logic [3:0] o_bus_identity,
    output logic o_identity_valid,
    output logic o_converter_on
);
    import rtid_pkg::*;

    rtid_byte_t power_report_select;
    rtid_byte_t meter_kind_select;
    rtid_byte_t converter_control;
    rtid_byte_t converter_result;
    rtid_byte_t rail_a_meter;
    rtid_byte_t rail_b_meter;
    rtid_byte_t rail_c_meter;
    rtid_strap_st_t strap_st;
    rtid_strap_st_t next_strap_st;
    logic [2:0] bulk_sync;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] strap_s3;
    logic [3:0] next_identity;
    logic [3:0] log2_len;
    logic power_kind;
    logic total_sel;
    rtid_src_t src;
    logic [7:0] next_result;

    rtid_avg_if avg_a ();
    rtid_avg_if avg_b ();
    rtid_avg_if avg_c ();

    // host writes to the three control registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            power_report_select <= `RTID_RST_REG;
            meter_kind_select <= `RTID_RST_REG;
            converter_control <= `RTID_RST_REG;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `RTID_OFS_POWER_REPORT_SELECT: power_report_select <= i_reg_wdata;
                `RTID_OFS_METER_KIND_SELECT: meter_kind_select <= i_reg_wdata;
                `RTID_OFS_CONVERTER_CONTROL: converter_control <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // read mux; unmapped offsets read zero, control registers read back all eight bits as written
    always_comb begin
        case (i_reg_addr)
            `RTID_OFS_RAIL_A_METER: o_reg_rdata = rail_a_meter;
            `RTID_OFS_RAIL_B_METER: o_reg_rdata = rail_b_meter;
            `RTID_OFS_RAIL_C_METER: o_reg_rdata = rail_c_meter;
            `RTID_OFS_POWER_REPORT_SELECT: o_reg_rdata = power_report_select;
            `RTID_OFS_METER_KIND_SELECT: o_reg_rdata = meter_kind_select;
            `RTID_OFS_CONVERTER_CONTROL: o_reg_rdata = converter_control;
            `RTID_OFS_CONVERTER_RESULT: o_reg_rdata = converter_result;
            default: o_reg_rdata = 8'h00;
        endcase
    end

    // converter source decode; code zero switches it off, unlisted codes leave the result held
    assign src = rtid_src_t'(converter_control[`RTID_CONV_SEL_HI:`RTID_CONV_SEL_LO]);
    assign o_converter_on = (src != RTID_SRC_OFF);

    always_comb begin
        case (src)
            RTID_SRC_BULK: next_result = i_volt_bulk;
            RTID_SRC_RAIL_A: next_result = i_volt_rail_a;
            RTID_SRC_RAIL_B: next_result = i_volt_rail_b;
            RTID_SRC_RAIL_C: next_result = i_volt_rail_c;
            RTID_SRC_LDO_HIGH: next_result = i_volt_ldo_high;
            RTID_SRC_LDO_LOW: next_result = i_volt_ldo_low;
            default: next_result = converter_result;
        endcase
    end

    // result holds its last value while the converter is off
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            converter_result <= `RTID_RST_REG;
        end else begin
            converter_result <= next_result;
        end
    end

    // meter configuration
    assign power_kind = meter_kind_select[`RTID_BIT_POWER_KIND];
    assign total_sel = power_kind & power_report_select[`RTID_BIT_TOTAL_POWER];
    always_comb begin
        case (converter_control[`RTID_AVG_HI:`RTID_AVG_LO])
            2'h0: log2_len = `RTID_AVG_LOG2_0;
            2'h1: log2_len = `RTID_AVG_LOG2_1;
            2'h2: log2_len = `RTID_AVG_LOG2_2;
            default: log2_len = `RTID_AVG_LOG2_3;
        endcase
    end

    // sample selection feeding the averagers
    assign avg_a.sample = total_sel ? i_pwr_total : (power_kind ? i_pwr_rail_a : i_cur_rail_a);
    assign avg_b.sample = power_kind ? i_pwr_rail_b : i_cur_rail_b;
    assign avg_c.sample = power_kind ? i_pwr_rail_c : i_cur_rail_c;
    assign avg_a.log2_len = log2_len;
    assign avg_b.log2_len = log2_len;
    assign avg_c.log2_len = log2_len;

    rtid_averager u_avg_a (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .bus(avg_a.avg)
    );
    rtid_averager u_avg_b (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .bus(avg_b.avg)
    );
    rtid_averager u_avg_c (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .bus(avg_c.avg)
    );

    // meters refresh only at window end, so a read never sees a partial sum
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rail_a_meter <= `RTID_RST_REG;
            rail_b_meter <= `RTID_RST_REG;
            rail_c_meter <= `RTID_RST_REG;
        end else begin
            if (avg_a.done) begin
                rail_a_meter <= avg_a.average;
            end
            if (avg_b.done) begin
                rail_b_meter <= {2'b00, avg_b.average[5:0]};
            end
            if (avg_c.done) begin
                rail_c_meter <= {2'b00, avg_c.average[5:0]};
            end
        end
    end

    // pin synchronisers: three stages, change accepted once stages 2 and 3 agree
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            bulk_sync <= 3'b000;
            strap_s1 <= 2'b00;
            strap_s2 <= 2'b00;
            strap_s3 <= 2'b00;
        end else begin
            bulk_sync <= {bulk_sync[1:0], i_bulk_supply_good};
            strap_s1 <= i_identity_strap;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
        end
    end

    // strap code: 00 ground, 01 open, 1x tied to the high ldo output
    always_comb begin
        case (strap_s3)
            2'b00: next_identity = `RTID_ID_GROUND;
            2'b01: next_identity = `RTID_ID_OPEN;
            default: next_identity = `RTID_ID_HIGH;
        endcase
    end

    // one-shot strap capture; only a power cycle (reset) rearms it
    always_comb begin
        case (strap_st)
            RTID_ST_WAIT: next_strap_st = (bulk_sync[2] & bulk_sync[1]) ? RTID_ST_SAMPLE : RTID_ST_WAIT;
            RTID_ST_SAMPLE: next_strap_st = (strap_s2 == strap_s3) ? RTID_ST_HELD : RTID_ST_SAMPLE;
            RTID_ST_HELD: next_strap_st = RTID_ST_HELD;
            default: next_strap_st = RTID_ST_WAIT;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            strap_st <= RTID_ST_WAIT;
            o_bus_identity <= `RTID_ID_OPEN;
            o_identity_valid <= 1'b0;
        end else begin
            strap_st <= next_strap_st;
            if (strap_st == RTID_ST_SAMPLE && next_strap_st == RTID_ST_HELD) begin
                o_bus_identity <= next_identity;
                o_identity_valid <= 1'b1;
            end
        end
    end

    // identity never changes once valid
    AST_ID_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_identity_valid |=> (o_identity_valid && $stable(o_bus_identity)))
        else $error("identity changed after capture");
    AST_ID_CODE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_identity_valid) |-> (o_bus_identity == `RTID_ID_GROUND && $past(strap_s3) == 2'b00)
        || (o_bus_identity == `RTID_ID_OPEN && $past(strap_s3) == 2'b01)
        || (o_bus_identity == `RTID_ID_HIGH && $past(strap_s3[1])))
        else $error("identity code does not match strap");
    AST_ID_NEEDS_BULK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!bulk_sync[2] && strap_st == RTID_ST_WAIT) |=> !o_identity_valid)
        else $error("identity captured without bulk supply");
    AST_CONV_ON: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_converter_on == (converter_control[7:3] != 5'h00))
        else $error("converter enable does not follow control field");
    AST_RESULT_A: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (src == RTID_SRC_RAIL_A) |=> (converter_result == $past(i_volt_rail_a)))
        else $error("result does not follow rail a");
    AST_RESULT_BULK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (src == RTID_SRC_BULK) |=> (converter_result == $past(i_volt_bulk)))
        else $error("result does not follow bulk input");
    AST_B_WIDTH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        rail_b_meter[7:6] == 2'b00 && rail_c_meter[7:6] == 2'b00)
        else $error("reserved meter bits set");
    AST_REFRESH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (converter_control[1:0] == 2'h0 && $stable(converter_control)) |=> avg_a.done)
        else $error("shortest window does not refresh every cycle");
    AST_TOTAL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (total_sel && converter_control[1:0] == 2'h0) |=> ##1 (rail_a_meter == $past(i_pwr_total, 2)))
        else $error("total power not reported");
    AST_KIND: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!power_kind && converter_control[1:0] == 2'h0) |=> ##1 (rail_b_meter[5:0] == $past(i_cur_rail_b[5:0], 2)))
        else $error("current not reported on rail b");
    // converter result follows each source one edge late and holds while off
    AST_RESULT_B: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (src == RTID_SRC_RAIL_B) |=> (converter_result == $past(i_volt_rail_b)))
        else $error("result does not follow rail b");
    AST_RESULT_C: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (src == RTID_SRC_RAIL_C) |=> (converter_result == $past(i_volt_rail_c)))
        else $error("result does not follow rail c");
    AST_RESULT_LDO_HIGH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (src == RTID_SRC_LDO_HIGH) |=> (converter_result == $past(i_volt_ldo_high)))
        else $error("result does not follow high ldo output");
    AST_RESULT_LDO_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (src == RTID_SRC_LDO_LOW) |=> (converter_result == $past(i_volt_ldo_low)))
        else $error("result does not follow low ldo output");
    AST_RESULT_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (src == RTID_SRC_OFF) |=> (converter_result == $past(converter_result)))
        else $error("result moved while converter off");
    // host writes land on the next edge; a write to a meter never lands
    AST_WRITE_LANDS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_reg_wr && i_reg_addr == `RTID_OFS_CONVERTER_CONTROL) |=> (converter_control == $past(i_reg_wdata)))
        else $error("converter control write lost");
    AST_RO_METER: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_reg_wr && i_reg_addr == `RTID_OFS_RAIL_A_METER && !avg_a.done) |=> $stable(rail_a_meter))
        else $error("write reached a read-only meter");
    // meters move only when their window closes, and carry the chosen kind
    AST_METER_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !avg_b.done |=> $stable(rail_b_meter))
        else $error("meter moved inside a window");
    AST_OWN_POWER: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (power_kind && !total_sel && converter_control[1:0] == 2'h0)
        |=> ##1 (rail_a_meter == $past(i_pwr_rail_a, 2)))
        else $error("own rail power not reported");
    AST_PWR_B: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (power_kind && converter_control[1:0] == 2'h0) |=> ##1 (rail_b_meter[5:0] == $past(i_pwr_rail_b[5:0], 2)))
        else $error("power not reported on rail b");
    AST_PWR_C: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (power_kind && converter_control[1:0] == 2'h0) |=> ##1 (rail_c_meter[5:0] == $past(i_pwr_rail_c[5:0], 2)))
        else $error("power not reported on rail c");
    // the identity fsm never leaves its held state short of reset
    AST_ID_ONE_SHOT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (strap_st == RTID_ST_HELD) |=> (strap_st == RTID_ST_HELD))
        else $error("strap capture rearmed without reset");
endmodule

/* File: tb/rtid_host_model.sv */
module rtid_host_model (
    // clock
    input wire logic i_clk,
    // register port toward the device
    output logic o_reg_wr,
    output logic [7:0] o_reg_addr,
    output rtid_pkg::rtid_byte_t o_reg_wdata,
    input wire rtid_pkg::rtid_byte_t i_reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import rtid_pkg::*;
    // idle port parks on an unmapped offset so a stray read shows zero
    initial begin
        o_reg_wr = 1'b0;
        o_reg_addr = 8'hff;
        o_reg_wdata = 8'h00;
    end
    // one-cycle strobe launched off the falling edge, held across one rising edge
    task automatic write(input logic [7:0] addr, input rtid_byte_t data);
        @(negedge i_clk);
        o_reg_addr = addr;
        o_reg_wdata = data;
        o_reg_wr = 1'b1;
        @(negedge i_clk);
        o_reg_wr = 1'b0;
        o_reg_wdata = ~data; // released data must not look like the last value
    endtask
    // read data is combinational, so it is taken once the address has settled
    task automatic read(input logic [7:0] addr, output rtid_byte_t data);
        @(negedge i_clk);
        o_reg_addr = addr;
        #1;
        data = i_reg_rdata;
    endtask
endmodule

/* File: tb/rtid_telemetry_tb_top.sv */
`include "rtid_map.svh"
module rtid_telemetry_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rtid_pkg::*;
    // row: power select, kind select, converter control, read offset, expected byte
    typedef struct packed {
        rtid_byte_t pwr_sel;
        rtid_byte_t kind_sel;
        rtid_byte_t conv_ctl;
        logic [7:0] addr;
        rtid_byte_t exp;
    } rtid_row_t;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic reg_wr;
    logic [7:0] reg_addr;
    rtid_byte_t reg_wdata, reg_rdata, seen, seen2;
    logic [7:0] inv = 8'h00;
    logic alt = 1'b0;
    logic bulk_good = 1'b0;
    logic [1:0] strap = 2'b00;
    logic [3:0] bus_id;
    logic id_valid, conv_on;
    int errors = 0;
    int total_checks = 0;
    logic [7:0] rw_ofs [3] = '{8'h1a, 8'h1b, 8'h30};
    logic [5:0] id_rows [3] = '{6'b00_1001, 6'b01_1000, 6'b10_1100};
    rtid_row_t rows [21] = '{40'h00_00_09_31_b1, 40'h00_00_11_31_a2, 40'h00_00_19_31_93,
        40'h00_00_21_31_84, 40'h00_00_29_31_75, 40'h00_00_31_31_66, 40'h00_00_31_30_31,
        40'h00_00_01_0c_18, 40'h00_00_01_0e_15, 40'h00_00_01_0f_2a, 40'h02_00_02_0c_18,
        40'h00_40_03_0c_3c, 40'h00_40_03_0e_37, 40'h00_40_03_0f_0e, 40'h02_40_01_0c_c9,
        40'h02_40_01_1a_02, 40'h02_40_01_1b_40, 40'h02_40_01_0d_00, 40'h00_40_00_0c_3c,
        40'h02_40_00_0c_c9, 40'h00_00_00_31_66};

    // 125 MHz clock
    always #4 i_clk = ~i_clk;
    // rail A current alternates so a one-sample window shows every refresh
    always @(negedge i_clk) alt <= ~alt;

    rtid_host_model host (.i_clk(i_clk), .o_reg_wr(reg_wr), .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata));

    rtid_telemetry uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_wr(reg_wr), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_volt_bulk(8'hb1 ^ inv),
        .i_volt_rail_a(8'ha2 ^ inv), .i_volt_rail_b(8'h93 ^ inv), .i_volt_rail_c(8'h84 ^ inv),
        .i_volt_ldo_high(8'h75 ^ inv), .i_volt_ldo_low(8'h66 ^ inv),
        .i_cur_rail_a((alt ? 8'h20 : 8'h10) ^ inv), .i_cur_rail_b(8'hd5 ^ inv),
        .i_cur_rail_c(8'hea ^ inv), .i_pwr_rail_a(8'h3c ^ inv), .i_pwr_rail_b(8'hf7 ^ inv),
        .i_pwr_rail_c(8'h4e ^ inv), .i_pwr_total(8'hc9 ^ inv), .i_bulk_supply_good(bulk_good),
        .i_identity_strap(strap), .o_bus_identity(bus_id), .o_identity_valid(id_valid),
        .o_converter_on(conv_on));

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] want);
        total_checks++;
        if (got !== want) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, want, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge i_clk);
        i_rst_b = 1'b0;
        repeat (3) @(negedge i_clk);
        i_rst_b = 1'b1;
    endtask

    // sampled readings follow the inverted inputs; B and C keep only six bits
    function automatic rtid_byte_t exp_of(input rtid_row_t r, input logic flip);
        logic [7:0] m;
        m = (r.addr == 8'h0e || r.addr == 8'h0f) ? 8'h3f : 8'hff;
        if (flip && r.addr inside {8'h0c, 8'h0e, 8'h0f, 8'h31}) begin
            return r.exp ^ m;
        end
        return r.exp;
    endfunction

    // watchdog sized well above the table passes and strap runs
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        close_out();
    end

    // main sequence
    initial begin
        do_reset();
        check("converter on after reset", {7'h0, conv_on}, 8'h00);
        foreach (rw_ofs[i]) begin
            host.read(rw_ofs[i], seen);
            check("reset value", seen, 8'h00);
        end
        $display("reset test done");
        // second pass inverts every sample so stuck or swapped sources show up
        for (int p = 0; p < 2; p++) begin
            @(negedge i_clk);
            inv = {8{p[0]}};
            foreach (rows[i]) begin
                host.write(`RTID_OFS_POWER_REPORT_SELECT, rows[i].pwr_sel);
                host.write(`RTID_OFS_METER_KIND_SELECT, rows[i].kind_sel);
                host.write(`RTID_OFS_CONVERTER_CONTROL, rows[i].conv_ctl);
                repeat (140) @(negedge i_clk);
                host.read(rows[i].addr, seen);
                check("table read", seen, exp_of(rows[i], p[0]));
                check("converter on", {7'h0, conv_on}, {7'h0, rows[i].conv_ctl[7:3] != 5'h00});
            end
            $display("table pass done");
        end
        // shortest window refreshes every cycle, so reads a cycle apart differ
        host.write(`RTID_OFS_CONVERTER_CONTROL, 8'h00);
        repeat (4) @(negedge i_clk);
        host.read(`RTID_OFS_RAIL_A_METER, seen);
        host.read(`RTID_OFS_RAIL_A_METER, seen2);
        check("one-sample refresh", seen ^ seen2, 8'h30);
        // a write to a read-only meter must not land
        host.write(`RTID_OFS_CONVERTER_CONTROL, 8'h03);
        repeat (140) @(negedge i_clk);
        host.write(`RTID_OFS_RAIL_A_METER, 8'h5a);
        host.read(`RTID_OFS_RAIL_A_METER, seen);
        check("read-only meter", seen, 8'he7);
        $display("refresh and read-only test done");
        // each strap state from a fresh power cycle, then a strap change is ignored
        foreach (id_rows[i]) begin
            @(negedge i_clk);
            bulk_good = 1'b0;
            strap = id_rows[i][5:4];
            do_reset();
            repeat (10) @(negedge i_clk);
            check("valid before supply", {7'h0, id_valid}, 8'h00);
            check("identity before supply", {4'h0, bus_id}, 8'h08);
            bulk_good = 1'b1;
            for (int n = 0; n < 20 && id_valid !== 1'b1; n++) @(negedge i_clk);
            check("identity", {4'h0, bus_id}, {4'h0, id_rows[i][3:0]});
            strap = ~strap;
            repeat (20) @(negedge i_clk);
            check("identity held", {4'h0, bus_id}, {4'h0, id_rows[i][3:0]});
            check("valid held", {7'h0, id_valid}, 8'h01);
        end
        $display("strap identity test done");
        close_out();
    end
endmodule
